// ==== crs_pkg.sv ====
// constants shared by the controller record and standby block
// assumes a single 250 MHz system clock and an apb3 register bus
package crs_pkg;
  // clock and time base
  localparam int unsigned CLK_MHZ      = 250;             // system clock rate
  localparam int unsigned HOUR_TICK_MIN = 6;              // hours counter step in minutes
  localparam int unsigned RTC_TICK_S   = 1;               // clock step in seconds
  localparam longint unsigned HOUR_TICK_CYC =
    longint'(HOUR_TICK_MIN) * 60 * longint'(CLK_MHZ) * 1000000;
  localparam longint unsigned RTC_TICK_CYC =
    longint'(RTC_TICK_S) * longint'(CLK_MHZ) * 1000000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;  // range select
  localparam logic [7:0] OFS_TURNS     = 8'h04;  // current sensor wire turns
  localparam logic [7:0] OFS_STATUS    = 8'h08;  // standby and clock state
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0c;  // sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;  // interrupt enables
  localparam logic [7:0] OFS_HOURS     = 8'h14;  // operating hours ticks
  localparam logic [7:0] OFS_RTC       = 8'h18;  // clock seconds
  localparam logic [7:0] OFS_CAL_SEL   = 8'h1c;  // channel for readback
  localparam logic [7:0] OFS_CAL_ABS   = 8'h20;  // absolute resistance
  localparam logic [7:0] OFS_CAL_INIT  = 8'h24;  // initial resistance
  localparam logic [7:0] OFS_CAL_DEV   = 8'h28;  // deviation, 0.1 percent
  localparam logic [7:0] OFS_EVT_COUNT = 8'h2c;  // stored entries
  localparam logic [7:0] OFS_EVT_INDEX = 8'h30;  // 0 selects the newest entry
  localparam logic [7:0] OFS_EVT_CODE  = 8'h34;  // code and timestamp valid
  localparam logic [7:0] OFS_EVT_TIME  = 8'h38;  // timestamp

  // reset values
  localparam logic [7:0] RST_TURNS = 8'h01;      // one pass through sensor

  // irq status bit positions
  localparam int unsigned IRQ_LOGGED  = 0;       // an entry was written
  localparam int unsigned IRQ_STANDBY = 1;       // standby entered
  localparam int unsigned IRQ_CAL     = 2;       // calibration finished
  localparam int unsigned IRQ_WRAP    = 3;       // oldest entry overwritten
  localparam int unsigned IRQ_W       = 4;

  // event codes written for calibration runs
  localparam logic [9:0] EVT_AUTO_CAL = 10'h3f0;  // zero calibration done
  localparam logic [9:0] EVT_BASE_CAL = 10'h3f1;  // baseline calibration done

  // output code scaling
  localparam int unsigned RANGE_LO_C  = 300;     // full scale, range bit low
  localparam int unsigned RANGE_HI_C  = 500;     // full scale, range bit high
  localparam int unsigned FAULT_STEPS = 15;      // fault levels step full scale / 15
endpackage

// ==== crs_records.sv ====
// controller records and standby: calibration store, standby, output code,
// operating hours, real time clock and event memory behind an apb3 slave
// assumes apb3 master, synchronous inputs, one clock and active low async reset
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module crs_records #(
  parameter int unsigned     CH_N     = 8,                      // calibration channels
  parameter int unsigned     DEPTH    = 400,                    // event entries
  parameter int unsigned     DAC_W    = 12,                     // output code width
  parameter longint unsigned HOUR_CYC = crs_pkg::HOUR_TICK_CYC, // cycles per hours tick
  parameter longint unsigned SEC_CYC  = crs_pkg::RTC_TICK_CYC   // cycles per second
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cal_done,
  input  wire logic              base_cal_done,
  input  wire logic [2:0]        cal_channel,
  input  wire logic [15:0]       cal_raw,
  input  wire logic              supply_low,
  input  wire logic              supply_ok,
  input  wire logic [9:0]        temp_c,
  input  wire logic              fault_active,
  input  wire logic [3:0]        fault_level,
  input  wire logic              err_event,
  input  wire logic [9:0]        err_code,
  output logic                   standby_active_flag,
  output logic                   pulse_enable,
  output logic [DAC_W-1:0]       dac_code,
  output logic                   irq
);
  localparam int unsigned PW = $clog2(DEPTH);                  // pointer width
  localparam logic [DAC_W-1:0] FULL = {DAC_W{1'b1}};           // full scale code
  localparam logic [PW:0] DEPTH_V = (PW+1)'(DEPTH);            // depth at count width, one bit over the pointer

  // apb decode
  wire         acc_wr  = psel & penable & pwrite;             // write takes effect here
  wire         setup   = psel & ~penable;                     // read data captured here
  wire         a_ctrl  = (paddr == crs_pkg::OFS_CTRL);
  wire         a_turns = (paddr == crs_pkg::OFS_TURNS);
  wire         a_stat  = (paddr == crs_pkg::OFS_STATUS);
  wire         a_istat = (paddr == crs_pkg::OFS_IRQ_STAT);
  wire         a_imask = (paddr == crs_pkg::OFS_IRQ_MASK);
  wire         a_hours = (paddr == crs_pkg::OFS_HOURS);
  wire         a_rtc   = (paddr == crs_pkg::OFS_RTC);
  wire         a_csel  = (paddr == crs_pkg::OFS_CAL_SEL);
  wire         a_cabs  = (paddr == crs_pkg::OFS_CAL_ABS);
  wire         a_cini  = (paddr == crs_pkg::OFS_CAL_INIT);
  wire         a_cdev  = (paddr == crs_pkg::OFS_CAL_DEV);
  wire         a_ecnt  = (paddr == crs_pkg::OFS_EVT_COUNT);
  wire         a_eidx  = (paddr == crs_pkg::OFS_EVT_INDEX);
  wire         a_ecode = (paddr == crs_pkg::OFS_EVT_CODE);
  wire         a_etime = (paddr == crs_pkg::OFS_EVT_TIME);
  wire         mapped  = a_ctrl | a_turns | a_stat | a_istat | a_imask | a_hours | a_rtc
                       | a_csel | a_cabs | a_cini | a_cdev | a_ecnt | a_eidx | a_ecode
                       | a_etime;

  // zero wait slave, unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // software state
  localparam int unsigned IRQ_W = crs_pkg::IRQ_W;  // interrupt sources
  logic              range_hi_ff;                  // full scale 500 when set
  logic [7:0]        turns_ff;                     // sensor wire passes
  logic [IRQ_W-1:0]  irq_mask_ff;                  // interrupt enables
  logic [2:0]        cal_sel_ff;                   // readback channel
  logic [PW-1:0]     evt_idx_ff;                   // readback age

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_hi_ff <= 1'b0;
      turns_ff    <= crs_pkg::RST_TURNS;
      irq_mask_ff <= '0;
      cal_sel_ff  <= 3'h0;
      evt_idx_ff  <= '0;
    end else if (acc_wr) begin
      if (a_ctrl) range_hi_ff <= pwdata[0];
      if (a_turns) turns_ff <= pwdata[7:0];
      if (a_imask) irq_mask_ff <= pwdata[IRQ_W-1:0];
      if (a_csel) cal_sel_ff <= pwdata[2:0];
      if (a_eidx) evt_idx_ff <= pwdata[PW-1:0];
    end
  end

  // calibration arithmetic on the raw per-turn measurement
  logic [15:0]        init_ff [CH_N];              // initial raw per channel
  logic [23:0]        abs_ff  [CH_N];              // absolute resistance, 0.1 mohm
  logic signed [15:0] dev_ff  [CH_N];              // deviation, 0.1 percent
  wire  [23:0]        abs_new = 24'(cal_raw) * 24'(turns_ff);
  wire  [15:0]        ini_cur = base_cal_done ? cal_raw : init_ff[cal_channel];
  wire  signed [27:0] diff_k  = 28'(signed'({1'b0, cal_raw}) - signed'({1'b0, ini_cur}))
                              * 28'sd1000;
  wire  signed [27:0] dev_q   = (ini_cur == 16'h0000) ? 28'sd0
                              : diff_k / signed'(28'({12'h000, ini_cur}));
  wire  signed [15:0] dev_new = 16'(dev_q);        // deviation ignores turns
  wire                any_cal = cal_done | base_cal_done;

  // one store per channel, written only when a run finishes
  genvar gc;
  generate
    for (gc = 0; gc < CH_N; gc++) begin : g_ch
      wire hit = any_cal & (cal_channel == 3'(gc));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          init_ff[gc] <= 16'h0000;
          abs_ff[gc]  <= 24'h000000;
          dev_ff[gc]  <= 16'sh0000;
        end else begin
          if (base_cal_done) init_ff[gc] <= cal_raw;
          if (hit) begin
            abs_ff[gc] <= abs_new;
            dev_ff[gc] <= dev_new;
          end
        end
      end
    end
  endgenerate

  // standby on low auxiliary supply, left only when supply is back in band
  logic standby_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) standby_ff <= 1'b0;
    else if (supply_low) standby_ff <= 1'b1;
    else if (supply_ok) standby_ff <= 1'b0;
  end
  assign standby_active_flag = standby_ff;
  assign pulse_enable        = ~standby_ff;           // no sealing or measuring pulses

  // output code selection: standby, then fault, then temperature
  wire [9:0]  range_c  = range_hi_ff ? 10'(crs_pkg::RANGE_HI_C) : 10'(crs_pkg::RANGE_LO_C);
  wire [DAC_W+9:0] t_mul = (DAC_W+10)'(temp_c) * (DAC_W+10)'(FULL);
  wire [DAC_W+9:0] t_div = t_mul / (DAC_W+10)'(range_c);
  wire [DAC_W-1:0] t_code = (temp_c >= range_c) ? FULL : t_div[DAC_W-1:0];
  wire [DAC_W+3:0] f_mul = (DAC_W+4)'(fault_level) * (DAC_W+4)'(FULL / DAC_W'(crs_pkg::FAULT_STEPS));
  wire [DAC_W-1:0] f_code = (fault_level > 4'(crs_pkg::FAULT_STEPS)) ? FULL : f_mul[DAC_W-1:0];
  wire [DAC_W-1:0] nxt_dac = standby_ff ? '0 : (fault_active ? f_code : t_code);
  logic [DAC_W-1:0] dac_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dac_ff <= '0;
    else dac_ff <= nxt_dac;
  end
  assign dac_code = dac_ff;

  // operating hours: one tick per six minutes, no clear path
  logic [39:0] hcyc_ff;
  logic [31:0] hours_ff;
  wire         hour_tick = (hcyc_ff == 40'(HOUR_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcyc_ff  <= 40'h0;
      hours_ff <= 32'h0;
    end else begin
      hcyc_ff <= hour_tick ? 40'h0 : hcyc_ff + 40'h1;
      if (hour_tick) hours_ff <= hours_ff + 32'h1;
    end
  end

  // real time clock in seconds, valid once software has set it
  logic [31:0] scyc_ff;
  logic [31:0] rtc_ff;
  logic        rtc_valid_ff;
  wire         sec_tick = (scyc_ff == 32'(SEC_CYC - 1));
  wire         rtc_wr   = acc_wr & a_rtc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scyc_ff      <= 32'h0;
      rtc_ff       <= 32'h0;
      rtc_valid_ff <= 1'b0;
    end else begin
      scyc_ff <= (sec_tick | rtc_wr) ? 32'h0 : scyc_ff + 32'h1;
      if (rtc_wr) begin
        rtc_ff       <= pwdata;
        rtc_valid_ff <= 1'b1;
      end else if (sec_tick) rtc_ff <= rtc_ff + 32'h1;
    end
  end

  // event source choice: external error first, then baseline, then zero run
  wire       ev_wr   = err_event | any_cal;
  wire [9:0] ev_code = err_event ? err_code
                     : (base_cal_done ? crs_pkg::EVT_BASE_CAL : crs_pkg::EVT_AUTO_CAL);

  // circular event memory, pointer wraps onto the oldest entry
  logic [PW-1:0] wptr_ff;
  logic [PW:0]   count_ff;
  wire           full     = (count_ff == DEPTH_V);
  wire [PW-1:0]  nxt_wptr = (wptr_ff == PW'(DEPTH - 1)) ? '0 : wptr_ff + PW'(1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff  <= '0;
      count_ff <= '0;
    end else if (ev_wr) begin
      wptr_ff <= nxt_wptr;
      if (!full) count_ff <= count_ff + (PW+1)'(1);
    end
  end

  logic [9:0]  e_code_ff [DEPTH];                  // stored codes
  logic [31:0] e_time_ff [DEPTH];                  // stored stamps
  logic        e_tval_ff [DEPTH];                  // stamp valid
  logic        e_used_ff [DEPTH];                  // entry written
  genvar ge;
  generate
    for (ge = 0; ge < DEPTH; ge++) begin : g_ev
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          e_code_ff[ge] <= 10'h000;
          e_time_ff[ge] <= 32'h0;
          e_tval_ff[ge] <= 1'b0;
          e_used_ff[ge] <= 1'b0;
        end else if (ev_wr && (wptr_ff == PW'(ge))) begin
          e_code_ff[ge] <= ev_code;
          e_time_ff[ge] <= rtc_ff;
          e_tval_ff[ge] <= rtc_valid_ff;
          e_used_ff[ge] <= 1'b1;
        end
      end
    end
  endgenerate

  // readback slot: newest is index 0
  wire [PW:0]   r_sum  = (PW+1)'(wptr_ff) + DEPTH_V - (PW+1)'(1) - (PW+1)'(evt_idx_ff);
  wire [PW:0]   r_mod  = (r_sum >= DEPTH_V) ? r_sum - DEPTH_V : r_sum;
  wire [PW-1:0] r_slot = (evt_idx_ff >= PW'(DEPTH)) ? '0 : r_mod[PW-1:0];

  // sticky interrupt status, hardware set wins over software clear
  logic [IRQ_W-1:0] irq_stat_ff;
  logic             standby_d_ff;
  wire  [IRQ_W-1:0] ev_set;
  assign ev_set[crs_pkg::IRQ_LOGGED]  = ev_wr;
  assign ev_set[crs_pkg::IRQ_STANDBY] = standby_ff & ~standby_d_ff;
  assign ev_set[crs_pkg::IRQ_CAL]     = any_cal;
  assign ev_set[crs_pkg::IRQ_WRAP]    = ev_wr & full;
  wire  [IRQ_W-1:0] w1c = (acc_wr & a_istat) ? pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff  <= '0;
      standby_d_ff <= 1'b0;
    end else begin
      irq_stat_ff  <= (irq_stat_ff & ~w1c) | ev_set;
      standby_d_ff <= standby_ff;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // read mux, captured in the setup cycle
  wire [31:0] rd_mux =
      a_ctrl  ? {31'h0, range_hi_ff}
    : a_turns ? {24'h0, turns_ff}
    : a_stat  ? {30'h0, rtc_valid_ff, standby_ff}
    : a_istat ? {28'h0, irq_stat_ff}
    : a_imask ? {28'h0, irq_mask_ff}
    : a_hours ? hours_ff
    : a_rtc   ? rtc_ff
    : a_csel  ? {29'h0, cal_sel_ff}
    : a_cabs  ? {8'h0, abs_ff[cal_sel_ff]}
    : a_cini  ? {16'h0, init_ff[cal_sel_ff]}
    : a_cdev  ? {{16{dev_ff[cal_sel_ff][15]}}, dev_ff[cal_sel_ff]}
    : a_ecnt  ? 32'(count_ff)
    : a_eidx  ? 32'(evt_idx_ff)
    : a_ecode ? {20'h0, e_used_ff[r_slot], e_tval_ff[r_slot], e_code_ff[r_slot]}
    : a_etime ? e_time_ff[r_slot]
    : 32'h0;
  logic [31:0] prdata_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= 32'h0;
    else if (setup) prdata_ff <= pwrite ? 32'h0 : rd_mux;
  end
  assign prdata = prdata_ff;

  // checks
  sequence low_seen;
    supply_low;
  endsequence
  sequence standby_out;
    standby_active_flag ##1 (dac_code == '0);
  endsequence

  standby_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_seen |=> standby_out) else $error("standby not entered on low supply");
  standby_leave_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!supply_low && supply_ok) |=> !standby_active_flag && pulse_enable)
    else $error("standby not left on supply recovery");
  fault_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!standby_ff && fault_active && fault_level == 4'h1)
      |=> dac_code == DAC_W'(FULL / DAC_W'(crs_pkg::FAULT_STEPS)))
    else $error("fault level not on output");
  temp_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!standby_ff && !fault_active && temp_c >= range_c) |=> dac_code == FULL)
    else $error("temperature full scale wrong");
  cal_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !any_cal |=> $stable(abs_ff[0]) && $stable(dev_ff[0]))
    else $error("resistance changed without a run");
  base_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    base_cal_done |=> init_ff[CH_N-1] == $past(cal_raw))
    else $error("initial resistance not stored");
  hours_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !hour_tick |=> $stable(hours_ff)) else $error("hours moved without a tick");
  evt_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    count_ff <= DEPTH_V) else $error("event count above depth");
  evt_stamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_wr |=> e_time_ff[$past(wptr_ff)] == $past(rtc_ff)
           && e_tval_ff[$past(wptr_ff)] == $past(rtc_valid_ff))
    else $error("entry stamp not taken from clock");
  evt_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_wr && wptr_ff == PW'(DEPTH - 1)) |=> wptr_ff == '0)
    else $error("pointer did not wrap to oldest");
  rtc_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    rtc_wr |=> rtc_valid_ff && rtc_ff == $past(pwdata)) else $error("clock set failed");
  rtc_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sec_tick && !rtc_wr) |=> rtc_ff == $past(rtc_ff) + 32'h1) else $error("clock did not advance");
  hours_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    hour_tick |=> hours_ff == $past(hours_ff) + 32'h1) else $error("hours did not advance");
  evt_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_wr |=> irq_stat_ff[crs_pkg::IRQ_LOGGED]) else $error("logged event flag not set");
endmodule
`default_nettype wire

// ==== crs_apb_host.sv ====
// apb3 master model for the fieldbus host side of the record block
// assumes one clock; the bench holds req until it sees done
`timescale 1ns/1ns
`default_nettype none
module crs_apb_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [7:0]  req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             done,
  output logic             rd_done,
  output logic [32:0]      result
);
  // idle: start on req; setup: raise penable; access: wait for pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 8'h00;
      pwdata  <= 32'h0;
      done    <= 1'b0;
      rd_done <= 1'b0;
      result  <= 33'h0;
    end else begin
      done    <= 1'b0;
      rd_done <= 1'b0;
      if (psel && penable && pready) begin
        // answer taken at this edge only, then release
        psel    <= 1'b0;
        penable <= 1'b0;
        done    <= 1'b1;
        rd_done <= !pwrite;
        result  <= {pslverr, prdata};
      end else if (psel) begin
        penable <= 1'b1;
      end else if (req && !done) begin
        // setup cycle; turns and clock settings leave here
        psel   <= 1'b1;
        pwrite <= req_wr;
        paddr  <= req_addr;
        pwdata <= req_wdata;
      end else begin
        // released bus shows a moving pattern, not the last value
        paddr  <= ~paddr;
        pwdata <= ~pwdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== controller_records_and_standby_test.sv ====
// self-checking bench for the record and standby block
// assumes crs_pkg, crs_records and the apb host model are compiled first
`timescale 1ns/1ns
`default_nettype none
module controller_records_and_standby_test;
  logic pclk = 1'b0, presetn = 1'b0, req = 1'b0, req_wr = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [31:0] req_wdata = 32'h0;
  logic cal_done = 1'b0, base_cal_done = 1'b0, supply_low = 1'b0, supply_ok = 1'b1;
  logic fault_active = 1'b0, err_event = 1'b0;
  logic [2:0] cal_channel = 3'h0;
  logic [15:0] cal_raw = 16'h0;
  logic [9:0] temp_c = 10'h0, err_code = 10'h0;
  logic [3:0] fault_level = 4'h0;
  wire logic psel, penable, pwrite, pready, pslverr, done, rd_done;
  wire logic [7:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [32:0] result;
  wire logic standby_active_flag, pulse_enable, irq;
  wire logic [11:0] dac_code;
  int err_total = 0, compares = 0, cyc = 0, cr, full, t, i;
  logic [7:0] turns;
  logic [15:0] raw;
  logic [2:0] ch;
  logic [32:0] exp_q[$];   // expected read results, oldest first

  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  crs_apb_host u_host (.pclk(pclk), .presetn(presetn), .req(req), .req_wr(req_wr),
    .req_addr(req_addr), .req_wdata(req_wdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .done(done), .rd_done(rd_done), .result(result));
  crs_records #(.HOUR_CYC(20), .SEC_CYC(10)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cal_done(cal_done),
    .base_cal_done(base_cal_done), .cal_channel(cal_channel), .cal_raw(cal_raw),
    .supply_low(supply_low), .supply_ok(supply_ok), .temp_c(temp_c),
    .fault_active(fault_active), .fault_level(fault_level), .err_event(err_event),
    .err_code(err_code), .standby_active_flag(standby_active_flag),
    .pulse_enable(pulse_enable), .dac_code(dac_code), .irq(irq));

  // one comparison, counted
  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer through the host model, bounded wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req_wr <= w;
    req_addr <= a;
    req_wdata <= d;
    req <= 1'b1;
    @(posedge pclk);
    while (done !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      err_total++;
      end_of_test();
    end
    req <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    exp_q.push_back({er, e});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic cal(input logic b, input logic [2:0] c, input logic [15:0] r);
    cal_channel <= c;
    cal_raw <= r;
    cal_done <= !b;
    base_cal_done <= b;
    @(posedge pclk);
    cal_done <= 1'b0;
    base_cal_done <= 1'b0;
    tick(2);
  endtask
  task automatic ev(input logic [9:0] c);
    err_code <= c;
    err_event <= 1'b1;
    @(posedge pclk);
    err_event <= 1'b0;
    @(posedge pclk);
  endtask

  // watcher: each read result against the oldest note
  always @(posedge pclk) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) cmp(result, 33'h1_dead_beef);
      else cmp(result, exp_q.pop_front());
    end
  end

  initial begin
    #40000;
    err_total++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'he76a));
    tick(5);
    presetn <= 1'b1;
    cr = cyc;
    @(posedge pclk);
    cmp(33'({irq, pulse_enable, dac_code}), 33'h1000);
    rd(crs_pkg::OFS_TURNS, 32'h1);
    rd(crs_pkg::OFS_STATUS, 32'h0);
    rd(8'hfc, 32'h0, 1'b1);
    // hours: sampled mid tick, a write must not disturb it
    while (cyc < cr + 210) @(posedge pclk);
    rd(crs_pkg::OFS_HOURS, 32'd10);
    xfer(1'b1, crs_pkg::OFS_HOURS, 32'h55);
    while (cyc < cr + 410) @(posedge pclk);
    rd(crs_pkg::OFS_HOURS, 32'd20);
    // calibration store, turns scaling and deviation
    turns = 8'($urandom_range(255, 2));
    raw = 16'($urandom_range(65535, 1));
    ch = 3'($urandom_range(7, 0));
    xfer(1'b1, crs_pkg::OFS_TURNS, 32'(turns));
    xfer(1'b1, crs_pkg::OFS_IRQ_MASK, 32'h4);
    cal(1'b0, ch, raw);
    cmp(33'(irq), 33'h1);
    xfer(1'b1, crs_pkg::OFS_CAL_SEL, 32'(ch));
    rd(crs_pkg::OFS_CAL_ABS, 32'(raw) * 32'(turns));
    xfer(1'b1, crs_pkg::OFS_CAL_SEL, 32'(ch ^ 3'h1));
    rd(crs_pkg::OFS_CAL_ABS, 32'h0);
    cal(1'b1, ch, 16'd1000);
    for (i = 0; i < 8; i++) begin
      xfer(1'b1, crs_pkg::OFS_CAL_SEL, 32'(i));
      rd(crs_pkg::OFS_CAL_INIT, 32'd1000);
    end
    cal(1'b0, 3'h3, 16'd1100);
    xfer(1'b1, crs_pkg::OFS_CAL_SEL, 32'h3);
    rd(crs_pkg::OFS_CAL_DEV, 32'd100);
    rd(crs_pkg::OFS_CAL_ABS, 32'd1100 * 32'(turns));
    cal(1'b0, 3'h3, 16'd900);
    rd(crs_pkg::OFS_CAL_DEV, 32'hffffff9c);
    xfer(1'b1, crs_pkg::OFS_IRQ_STAT, 32'hf);
    cmp(33'(irq), 33'h0);
    // output code for both ranges, then fault levels 1 to 15
    for (i = 0; i < 2; i++) begin
      xfer(1'b1, crs_pkg::OFS_CTRL, 32'(i));
      full = (i == 1) ? 500 : 300;
      t = $urandom_range(full - 1, 0);
      temp_c <= 10'(t);
      tick(3);
      cmp(33'(dac_code), 33'(t * 4095 / full));
      temp_c <= 10'(full);
      tick(3);
      cmp(33'(dac_code), 33'd4095);
    end
    fault_active <= 1'b1;
    for (i = 1; i < 16; i++) begin
      fault_level <= 4'(i);
      tick(3);
      cmp(33'(dac_code), 33'(i * 273));
    end
    // standby wins over fault; it holds until supply_ok returns
    supply_low <= 1'b1;
    tick(3);
    cmp(33'({standby_active_flag, pulse_enable, dac_code}), 33'h2000);
    rd(crs_pkg::OFS_STATUS, 32'h1);
    rd(crs_pkg::OFS_IRQ_STAT, 32'h2);
    supply_low <= 1'b0;
    supply_ok <= 1'b0;
    tick(3);
    cmp(33'({standby_active_flag, pulse_enable, dac_code}), 33'h2000);
    supply_ok <= 1'b1;
    tick(3);
    cmp(33'({standby_active_flag, pulse_enable, dac_code}), 33'h1fff);
    fault_active <= 1'b0;
    // events before and after the clock is set
    ev(10'h155);
    xfer(1'b1, crs_pkg::OFS_RTC, 32'h1234);
    rd(crs_pkg::OFS_RTC, 32'h1234);
    ev(10'h2a3);
    rd(crs_pkg::OFS_STATUS, 32'h2);
    xfer(1'b1, crs_pkg::OFS_EVT_INDEX, 32'h0);
    rd(crs_pkg::OFS_EVT_CODE, 32'hea3);
    rd(crs_pkg::OFS_EVT_TIME, 32'h1234);
    xfer(1'b1, crs_pkg::OFS_EVT_INDEX, 32'h1);
    rd(crs_pkg::OFS_EVT_CODE, 32'h955);
    // back to back fill past capacity
    xfer(1'b1, crs_pkg::OFS_IRQ_MASK, 32'h8);
    for (i = 0; i < 405; i++) begin
      err_code <= 10'(i);
      err_event <= 1'b1;
      @(posedge pclk);
    end
    err_event <= 1'b0;
    @(posedge pclk);
    cmp(33'(irq), 33'h1);
    rd(crs_pkg::OFS_EVT_COUNT, 32'd400);
    xfer(1'b1, crs_pkg::OFS_EVT_INDEX, 32'h0);
    rd(crs_pkg::OFS_EVT_CODE, 32'hd94);
    xfer(1'b1, crs_pkg::OFS_EVT_INDEX, 32'd399);
    rd(crs_pkg::OFS_EVT_CODE, 32'hc05);
    xfer(1'b1, crs_pkg::OFS_IRQ_STAT, 32'h8);
    cmp(33'(irq), 33'h0);
    tick(2);
    end_of_test();
  end
endmodule
`default_nettype wire
